/* File: bra_pkg.sv */
/*
 * Shared constants for the bit-reversed effective-address generator: register
 * offsets, field positions, reset values and the addressing-mode and unit codes.
 * Assumes a 16-bit data space with byte addressing and a single core clock.
 */
`default_nettype none

package bra_pkg;

  // ****************************************************************
  // Register map and field layout
  // ****************************************************************
  localparam int          BRA_ADDR_W        = 4;
  localparam int          BRA_DATA_W        = 16;
  localparam logic [3:0]  BRA_OFS_MODCTL    = 4'h0;
  localparam logic [3:0]  BRA_OFS_XSTART    = 4'h1;
  localparam logic [3:0]  BRA_OFS_XEND      = 4'h2;
  localparam logic [3:0]  BRA_OFS_YSTART    = 4'h3;
  localparam logic [3:0]  BRA_OFS_YEND      = 4'h4;
  localparam logic [3:0]  BRA_OFS_REVCTL    = 4'h5;
  localparam logic [3:0]  BRA_OFS_LAST_EA   = 4'h6;
  localparam logic [3:0]  BRA_OFS_STATUS    = 4'h7;

  localparam int          BRA_MOD_XEN_BIT   = 15;
  localparam int          BRA_MOD_YEN_BIT   = 14;
  localparam int          BRA_MOD_YSEL_LSB  = 8;
  localparam int          BRA_MOD_XSEL_LSB  = 4;
  localparam int          BRA_MOD_RSEL_LSB  = 0;
  localparam int          BRA_REV_EN_BIT    = 15;
  localparam int          BRA_PIVOT_W       = 15;

  localparam logic [15:0] BRA_MODCTL_RST    = 16'h0FFF;
  localparam logic [15:0] BRA_REVCTL_RST    = 16'h0000;
  localparam logic [15:0] BRA_BOUND_RST     = 16'h0000;
  localparam logic [3:0]  BRA_SEL_NONE      = 4'hF;

  // ****************************************************************
  // Addressing modes and address units
  // ****************************************************************
  typedef enum logic [2:0] {
    BRA_MODE_DIRECT   = 3'h0,
    BRA_MODE_POST_DEC = 3'h1,
    BRA_MODE_POST_INC = 3'h3,
    BRA_MODE_PRE_INC  = 3'h2,
    BRA_MODE_PRE_DEC  = 3'h6,
    BRA_MODE_OFFSET   = 3'h7
  } bra_mode_t;

  typedef enum logic [1:0] {
    BRA_UNIT_XREAD  = 2'h0,
    BRA_UNIT_XWRITE = 2'h1,
    BRA_UNIT_Y      = 2'h3
  } bra_unit_t;

endpackage : bra_pkg

`default_nettype wire

/* File: bra_rev_adder.sv */
/*
 * Reverse-carry adder: adds a pivot modifier to a byte pointer with the carry
 * running from the most significant bit downward, producing a word address.
 * Purely combinational; the caller registers the result.
 */
`default_nettype none

module bra_rev_adder
  import bra_pkg::*;
#(
  parameter int ADDR_W  = 16,
  parameter int PIVOT_W = 15
)
(
  input  wire logic [ADDR_W-1:0]  ptr,
  input  wire logic [PIVOT_W-1:0] pivot,
  output logic      [ADDR_W-1:0]  sum
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  // The pivot counts words, so it must span exactly the word index.
  if (PIVOT_W != ADDR_W - 1)
  begin : g_width_check
    $error("bra_rev_adder: PIVOT_W must equal ADDR_W - 1");
  end

  logic [PIVOT_W-1:0] ptr_rev;
  logic [PIVOT_W-1:0] piv_rev;
  logic [PIVOT_W-1:0] sum_rev;

  // ****************************************************************
  // Bit reversal of both operands and of the result
  // ****************************************************************
  // Reversing, adding normally and reversing back gives the reverse-carry sum.
  for (genvar i = 0; i < PIVOT_W; i++)
  begin : g_rev
    assign ptr_rev[i]  = ptr[ADDR_W-1-i];
    assign piv_rev[i]  = pivot[PIVOT_W-1-i];
    assign sum[ADDR_W-1-i] = sum_rev[i];
  end

  // The word index is ptr[15:1]; the pivot is scaled to bytes by the shift.
  assign sum_rev = ptr_rev + piv_rev;
  assign sum[0]  = 1'b0;

endmodule : bra_rev_adder

`default_nettype wire

/* File: bra_addr_gen.sv */
/*
 * Effective-address generator for the data-space address units with
 * bit-reversed and modulo addressing, plus its control registers.
 * Assumes the instruction decoder presents one request per cycle with the
 * pointer value read from the working registers, and that it commits the
 * write-back itself from the registered outputs.
 */
// Design decisions made here: the placing of the registers and the plain strobed port.
`default_nettype none

module bra_addr_gen
  import bra_pkg::*;
#(
  parameter int ADDR_W  = 16,
  parameter int PIVOT_W = 15
)
(
  input  wire logic                  CORE_CLK,
  input  wire logic                  NRST,
  // Register port.
  input  wire logic [BRA_ADDR_W-1:0] REG_ADDR,
  input  wire logic [BRA_DATA_W-1:0] REG_WDATA,
  input  wire logic                  REG_WR,
  input  wire logic                  REG_RD,
  output logic      [BRA_DATA_W-1:0] REG_RDATA,
  // Request from the instruction decoder.
  input  wire logic                  AGU_REQ,
  input  wire logic [1:0]            AGU_UNIT,
  input  wire logic [2:0]            AGU_MODE,
  input  wire logic                  AGU_BYTE,
  input  wire logic [3:0]            AGU_PTR_IDX,
  input  wire logic [ADDR_W-1:0]     AGU_PTR_VAL,
  input  wire logic [ADDR_W-1:0]     AGU_OFFSET,
  // Answer to the decoder, one cycle after the request.
  output logic                       EA_VALID,
  output logic      [ADDR_W-1:0]     EA_ADDR,
  output logic                       WB_EN,
  output logic      [3:0]            WB_IDX,
  output logic      [ADDR_W-1:0]     WB_VAL,
  output logic                       REV_ACTIVE,
  output logic                       MOD_APPLIED
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (ADDR_W != BRA_DATA_W || PIVOT_W != BRA_PIVOT_W)
  begin : g_param_check
    $error("bra_addr_gen: widths must match the 16-bit data path");
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  logic [BRA_DATA_W-1:0] modulo_control_reg;
  logic [BRA_DATA_W-1:0] reverse_control_reg;
  logic [ADDR_W-1:0]     x_start_reg;
  logic [ADDR_W-1:0]     x_end_reg;
  logic [ADDR_W-1:0]     y_start_reg;
  logic [ADDR_W-1:0]     y_end_reg;
  logic [BRA_DATA_W-1:0] rdata_reg;

  logic [3:0]         reverse_pointer_select;
  logic [3:0]         x_mod_select;
  logic [3:0]         y_mod_select;
  logic               x_mod_enable;
  logic               y_mod_enable;
  logic               reverse_enable;
  logic [PIVOT_W-1:0] pivot_modifier;

  assign reverse_pointer_select = modulo_control_reg[BRA_MOD_RSEL_LSB +: 4];
  assign x_mod_select           = modulo_control_reg[BRA_MOD_XSEL_LSB +: 4];
  assign y_mod_select           = modulo_control_reg[BRA_MOD_YSEL_LSB +: 4];
  assign x_mod_enable           = modulo_control_reg[BRA_MOD_XEN_BIT];
  assign y_mod_enable           = modulo_control_reg[BRA_MOD_YEN_BIT];
  assign reverse_enable         = reverse_control_reg[BRA_REV_EN_BIT];
  assign pivot_modifier         = reverse_control_reg[PIVOT_W-1:0];

  // Software writes; a write to an unmapped or read-only offset is dropped.
  always_ff @(posedge CORE_CLK)
  begin
    if (!NRST)
    begin
      modulo_control_reg  <= BRA_MODCTL_RST;
      reverse_control_reg <= BRA_REVCTL_RST;
      x_start_reg         <= BRA_BOUND_RST;
      x_end_reg           <= BRA_BOUND_RST;
      y_start_reg         <= BRA_BOUND_RST;
      y_end_reg           <= BRA_BOUND_RST;
    end
    else if (REG_WR)
    begin
      unique case (REG_ADDR)
        BRA_OFS_MODCTL: modulo_control_reg  <= REG_WDATA;
        BRA_OFS_XSTART: x_start_reg         <= REG_WDATA;
        BRA_OFS_XEND:   x_end_reg           <= REG_WDATA;
        BRA_OFS_YSTART: y_start_reg         <= REG_WDATA;
        BRA_OFS_YEND:   y_end_reg           <= REG_WDATA;
        BRA_OFS_REVCTL: reverse_control_reg <= REG_WDATA;
        default:        ;
      endcase
    end
  end

  // ****************************************************************
  // Request decode
  // ****************************************************************
  logic        is_inc;
  logic        is_dec;
  logic        is_pre;
  logic        is_modify;
  logic        rev_cfg;
  logic        rev_now;
  logic        mod_sel;
  logic        mod_allowed;
  logic        mod_now;
  logic [ADDR_W-1:0] step_addr;
  logic [ADDR_W-1:0] norm_addr;
  logic [ADDR_W-1:0] rev_addr;
  logic [ADDR_W-1:0] mod_start;
  logic [ADDR_W-1:0] mod_end;
  logic [ADDR_W-1:0] mod_len;
  logic [ADDR_W-1:0] corr_addr;
  logic [ADDR_W-1:0] new_addr;
  logic [ADDR_W-1:0] ea_next;

  assign is_inc    = (AGU_MODE == BRA_MODE_POST_INC) || (AGU_MODE == BRA_MODE_PRE_INC);
  assign is_dec    = (AGU_MODE == BRA_MODE_POST_DEC) || (AGU_MODE == BRA_MODE_PRE_DEC);
  assign is_pre    = (AGU_MODE == BRA_MODE_PRE_INC)  || (AGU_MODE == BRA_MODE_PRE_DEC);
  assign is_modify = is_inc || is_dec;

  // A control write takes effect at its own edge, so the very next request
  // already sees the new pivot and enable. There is no stale-setting window
  // for software to step around, at the price of a longer decode path.
  // Bit reversal is configured when enabled and a pointer other than the stack is chosen.
  assign rev_cfg = reverse_enable && (reverse_pointer_select != BRA_SEL_NONE);

  // It acts only on word writes through the chosen pointer with an increment.
  assign rev_now = rev_cfg
                && (AGU_UNIT == BRA_UNIT_XWRITE)
                && (AGU_PTR_IDX == reverse_pointer_select)
                && is_inc
                && !AGU_BYTE;

  // Modulo follows the unit's own pointer select; reversal switches it off for
  // the X write and Y units but the X read unit keeps its correction.
  always_comb
  begin
    mod_start = x_start_reg;
    mod_end   = x_end_reg;
    mod_sel   = x_mod_enable && (AGU_PTR_IDX == x_mod_select);
    if (AGU_UNIT == BRA_UNIT_Y)
    begin
      mod_start = y_start_reg;
      mod_end   = y_end_reg;
      mod_sel   = y_mod_enable && (AGU_PTR_IDX == y_mod_select);
    end
  end

  assign mod_allowed = (AGU_UNIT == BRA_UNIT_XREAD) || !rev_cfg;
  assign mod_now     = mod_sel && mod_allowed && !rev_now
                    && (is_modify || (AGU_MODE == BRA_MODE_OFFSET));
  // The length wraps to a meaningless value when start exceeds end; software must program
  // an ordered pair, because nothing here checks it.
  assign mod_len     = ADDR_W'(mod_end - mod_start + 16'h0001);

  // ****************************************************************
  // Address arithmetic
  // ****************************************************************
  // Normal address: pointer moved by the mode's step or by the offset.
  always_comb
  begin
    step_addr = AGU_BYTE ? 16'h0001 : 16'h0002;
    unique case (AGU_MODE)
      BRA_MODE_POST_INC,
      BRA_MODE_PRE_INC:  norm_addr = ADDR_W'(AGU_PTR_VAL + step_addr);
      BRA_MODE_POST_DEC,
      BRA_MODE_PRE_DEC:  norm_addr = ADDR_W'(AGU_PTR_VAL - step_addr);
      BRA_MODE_OFFSET:   norm_addr = ADDR_W'(AGU_PTR_VAL + AGU_OFFSET);
      default:           norm_addr = AGU_PTR_VAL;
    endcase
  end

  // Reverse-carry sum of the pointer and the pivot; the step is not used.
  bra_rev_adder #(
    .ADDR_W  (ADDR_W),
    .PIVOT_W (PIVOT_W)
  ) u_rev_adder (
    .ptr   (AGU_PTR_VAL),
    .pivot (pivot_modifier),
    .sum   (rev_addr)
  );

  // Modulo correction checks beyond the bound, not only equality, so a step
  // that jumps past the end still folds back into the buffer.
  always_comb
  begin
    corr_addr = norm_addr;
    if (is_dec && (norm_addr < mod_start))
    begin
      corr_addr = ADDR_W'(norm_addr + mod_len);
    end
    else if (!is_dec && (norm_addr > mod_end))
    begin
      corr_addr = ADDR_W'(norm_addr - mod_len);
    end
  end

  always_comb
  begin
    if (rev_now)
    begin
      new_addr = rev_addr;
    end
    else if (mod_now)
    begin
      new_addr = corr_addr;
    end
    else
    begin
      new_addr = norm_addr;
    end
  end

  // Post-modify accesses use the old pointer, pre-modify and offset the new one.
  always_comb
  begin
    if (is_modify && !is_pre)
    begin
      ea_next = AGU_PTR_VAL;
    end
    else
    begin
      ea_next = new_addr;
    end
  end

  // ****************************************************************
  // Registered answer
  // ****************************************************************
  // One registered stage keeps every output glitch free for the decoder.
  // The block never forwards its own write-back, so the decoder must present
  // a pointer value that already holds the previous request's update.
  always_ff @(posedge CORE_CLK)
  begin
    if (!NRST)
    begin
      EA_VALID    <= 1'b0;
      EA_ADDR     <= '0;
      WB_EN       <= 1'b0;
      WB_IDX      <= 4'h0;
      WB_VAL      <= '0;
      REV_ACTIVE  <= 1'b0;
      MOD_APPLIED <= 1'b0;
    end
    else
    begin
      EA_VALID    <= AGU_REQ;
      WB_EN       <= AGU_REQ && is_modify;
      REV_ACTIVE  <= AGU_REQ && rev_now;
      MOD_APPLIED <= AGU_REQ && mod_now;
      if (AGU_REQ)
      begin
        EA_ADDR <= ea_next;
        WB_IDX  <= AGU_PTR_IDX;
        WB_VAL  <= new_addr;
      end
    end
  end

  // ****************************************************************
  // Register read port
  // ****************************************************************
  // Read data stand for exactly the cycle after the strobe, zero otherwise.
  // Status bits 1 and 0 are pulses, so a read shows them only when a request
  // is answered at the edge just before the one that samples the strobe.
  always_ff @(posedge CORE_CLK)
  begin
    if (!NRST)
    begin
      rdata_reg <= '0;
    end
    else if (REG_RD)
    begin
      unique case (REG_ADDR)
        BRA_OFS_MODCTL:  rdata_reg <= modulo_control_reg;
        BRA_OFS_XSTART:  rdata_reg <= x_start_reg;
        BRA_OFS_XEND:    rdata_reg <= x_end_reg;
        BRA_OFS_YSTART:  rdata_reg <= y_start_reg;
        BRA_OFS_YEND:    rdata_reg <= y_end_reg;
        BRA_OFS_REVCTL:  rdata_reg <= reverse_control_reg;
        BRA_OFS_LAST_EA: rdata_reg <= EA_ADDR;
        BRA_OFS_STATUS:  rdata_reg <= {13'h0000, rev_cfg, REV_ACTIVE, MOD_APPLIED};
        default:         rdata_reg <= '0;
      endcase
    end
    else
    begin
      rdata_reg <= '0;
    end
  end

  assign REG_RDATA = rdata_reg;

endmodule : bra_addr_gen

`default_nettype wire

/* File: bra_core_model.sv */
/*
 * Model of the instruction decoder and working-register file facing the generator.
 * Assumes the bench drives go, idx and the load port at rising clock edges.
 */
`default_nettype none

module bra_core_model
  import bra_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        go,
  input  wire logic [3:0]  idx,
  input  wire logic        ld,
  input  wire logic [15:0] ld_val,
  input  wire logic        WB_EN,
  input  wire logic [3:0]  WB_IDX,
  input  wire logic [15:0] WB_VAL,
  output logic             AGU_REQ,
  output logic      [3:0]  AGU_PTR_IDX,
  output logic      [15:0] AGU_PTR_VAL
);
  // ****************************************************************
  // Working registers
  // ****************************************************************
  logic [15:0] w_reg [16];

  initial foreach (w_reg[i]) w_reg[i] = 16'h0000;

  // The bench loads pointers; otherwise the generator's write-back is committed.
  always @(posedge CORE_CLK)
  begin
    if (ld) w_reg[idx] <= ld_val;
    else if (WB_EN) w_reg[WB_IDX] <= WB_VAL;
  end

  // Forwarding the pending write-back lets back-to-back requests walk a buffer.
  assign AGU_REQ     = go;
  assign AGU_PTR_IDX = idx;
  assign AGU_PTR_VAL = (WB_EN && WB_IDX == idx) ? WB_VAL : w_reg[idx];
endmodule : bra_core_model

`default_nettype wire

/* File: bra_addr_gen_sva.sv */
/*
 * Checker for the address generator's request path, bound to its top module.
 * Assumes one clock and the synchronous active-low reset.
 */
`default_nettype none

module bra_addr_gen_chk
  import bra_pkg::*;
#(
  parameter int ADDR_W  = 16,
  parameter int PIVOT_W = 15
)
(
  input wire logic              CORE_CLK,
  input wire logic              NRST,
  input wire logic [1:0]        AGU_UNIT,
  input wire logic [2:0]        AGU_MODE,
  input wire logic              AGU_BYTE,
  input wire logic [3:0]        AGU_PTR_IDX,
  input wire logic [ADDR_W-1:0] AGU_PTR_VAL,
  input wire logic              EA_VALID,
  input wire logic [ADDR_W-1:0] EA_ADDR,
  input wire logic              WB_EN,
  input wire logic [3:0]        WB_IDX,
  input wire logic [ADDR_W-1:0] WB_VAL,
  input wire logic              REV_ACTIVE,
  input wire logic              MOD_APPLIED
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  rev_unit_a: assert property (REV_ACTIVE |-> $past(AGU_UNIT) == 2'h1)
    else $error("Reversal outside the X write unit.");
  rev_gate_a: assert property (REV_ACTIVE |-> ($past(AGU_MODE) inside {3'h2, 3'h3})
    && !$past(AGU_BYTE) && $past(AGU_PTR_IDX) != 4'hF) else $error("Reversal gate wrong.");
  rev_lsb_a: assert property (REV_ACTIVE |-> !EA_ADDR[0] && !WB_VAL[0])
    else $error("Reversed address not word aligned.");
  rev_nomod_a: assert property (REV_ACTIVE |-> !MOD_APPLIED)
    else $error("Modulo applied beside reversal.");
  wb_none_a: assert property (EA_VALID && ($past(AGU_MODE) inside {3'h0, 3'h7}) |-> !WB_EN)
    else $error("Write-back without modify mode.");
  wb_modify_a: assert property (EA_VALID && ($past(AGU_MODE) inside {3'h1, 3'h3})
    |-> WB_EN && WB_IDX == $past(AGU_PTR_IDX)) else $error("Missing write-back.");
  rev_order_a: assert property (REV_ACTIVE |-> ($past(AGU_MODE) == 3'h3)
    ? EA_ADDR == $past(AGU_PTR_VAL) : EA_ADDR == WB_VAL) else $error("Pre or post order wrong.");
  byte_step_a: assert property (EA_VALID && $past(AGU_BYTE) && $past(AGU_MODE) == 3'h3
    && !MOD_APPLIED |-> WB_VAL == $past(AGU_PTR_VAL) + 16'h0001) else $error("Byte step wrong.");

  cover property (REV_ACTIVE ##1 REV_ACTIVE);
  cover property (MOD_APPLIED && WB_EN);
  cover property (EA_VALID && !WB_EN);
endmodule : bra_addr_gen_chk

bind bra_addr_gen bra_addr_gen_chk #(.ADDR_W(ADDR_W), .PIVOT_W(PIVOT_W)) u_chk (
  .CORE_CLK(CORE_CLK), .NRST(NRST), .AGU_UNIT(AGU_UNIT), .AGU_MODE(AGU_MODE),
  .AGU_BYTE(AGU_BYTE), .AGU_PTR_IDX(AGU_PTR_IDX), .AGU_PTR_VAL(AGU_PTR_VAL),
  .EA_VALID(EA_VALID), .EA_ADDR(EA_ADDR), .WB_EN(WB_EN), .WB_IDX(WB_IDX),
  .WB_VAL(WB_VAL), .REV_ACTIVE(REV_ACTIVE), .MOD_APPLIED(MOD_APPLIED));

`default_nettype wire

/* File: bra_addr_gen_tb_top.sv */
/*
 * Self-checking bench for the address generator with the core model beside it.
 * Assumes a 125 MHz clock and registers reached over the plain strobe port.
 */
`default_nettype none

module bra_addr_gen_tb_top
  import bra_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic        clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0;
  logic        byte_acc = 1'b0, ld = 1'b0, agu_req, ea_valid, wb_en, rev_active, mod_applied;
  logic [3:0]  reg_addr = 4'h0, idx = 4'h0, ptr_idx, wb_idx;
  logic [1:0]  unit = 2'h0;
  logic [2:0]  mode = 3'h0;
  logic [15:0] reg_wdata = 16'h0000, offset = 16'h0000, ld_val = 16'h0000;
  logic [15:0] reg_rdata, ptr_val, ea_addr, wb_val;
  int          mismatches = 0, cmp_count = 0;

  always #4 clk = ~clk;

  bra_addr_gen DUT (.CORE_CLK(clk), .NRST(nrst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .AGU_REQ(agu_req),
    .AGU_UNIT(unit), .AGU_MODE(mode), .AGU_BYTE(byte_acc), .AGU_PTR_IDX(ptr_idx),
    .AGU_PTR_VAL(ptr_val), .AGU_OFFSET(offset), .EA_VALID(ea_valid), .EA_ADDR(ea_addr),
    .WB_EN(wb_en), .WB_IDX(wb_idx), .WB_VAL(wb_val), .REV_ACTIVE(rev_active),
    .MOD_APPLIED(mod_applied));

  bra_core_model u_core (.CORE_CLK(clk), .go(go), .idx(idx), .ld(ld), .ld_val(ld_val),
    .WB_EN(wb_en), .WB_IDX(wb_idx), .WB_VAL(wb_val), .AGU_REQ(agu_req),
    .AGU_PTR_IDX(ptr_idx), .AGU_PTR_VAL(ptr_val));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk) reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk) reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd

  task automatic load(input logic [3:0] i, input logic [15:0] v);
    @(posedge clk) {ld, idx, ld_val} <= {1'b1, i, v};
    @(posedge clk) ld <= 1'b0;
  endtask : load

  task automatic issue(input logic [1:0] u, input logic [2:0] m, input logic b,
                       input logic [3:0] i, input logic [15:0] o);
    @(posedge clk) {go, unit, mode, byte_acc, idx, offset} <= {1'b1, u, m, b, i, o};
  endtask : issue

  // Outputs stand one cycle after the request edge and are checked there.
  task automatic take(input logic last, input logic [15:0] ea, input logic wbe,
                      input logic [15:0] wbv, input logic rev, input logic mdf);
    @(posedge clk) if (last) go <= 1'b0;
    #1 chk(ea_valid, 1'b1);
    chk(ea_addr, ea);
    chk(wb_en, wbe);
    if (wbe) chk(wb_val, wbv);
    if (wbe) chk(wb_idx, idx);
    chk(rev_active, rev);
    chk(mod_applied, mdf);
  endtask : take

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    #100us mismatches++;
    give_verdict();
  end

  initial
  begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    rd(BRA_OFS_MODCTL, BRA_MODCTL_RST);
    rd(BRA_OFS_REVCTL, BRA_REVCTL_RST);
    rd(4'h9, 16'h0000);
    wr(BRA_OFS_MODCTL, 16'h0FF2);
    wr(BRA_OFS_REVCTL, 16'h8004);
    rd(BRA_OFS_REVCTL, 16'h8004);
    // Read data must fall back to zero one cycle later.
    @(posedge clk) #1 chk(reg_rdata, 16'h0000);
    load(4'h2, 16'h1000);
    load(4'h3, 16'h2000);
    // Back-to-back walk of an eight-word buffer with half-size pivot.
    issue(2'h1, BRA_MODE_POST_INC, 1'b0, 4'h2, 16'h0000);
    take(1'b0, 16'h1000, 1'b1, 16'h1008, 1'b1, 1'b0);
    take(1'b0, 16'h1008, 1'b1, 16'h1004, 1'b1, 1'b0);
    take(1'b0, 16'h1004, 1'b1, 16'h100C, 1'b1, 1'b0);
    take(1'b1, 16'h100C, 1'b1, 16'h1002, 1'b1, 1'b0);
    issue(2'h1, BRA_MODE_PRE_INC, 1'b0, 4'h2, 16'h0000);
    take(1'b1, 16'h100A, 1'b1, 16'h100A, 1'b1, 1'b0);
    issue(2'h1, BRA_MODE_POST_INC, 1'b1, 4'h2, 16'h0000);
    take(1'b1, 16'h100A, 1'b1, 16'h100B, 1'b0, 1'b0);
    issue(2'h0, BRA_MODE_POST_INC, 1'b0, 4'h2, 16'h0000);
    take(1'b1, 16'h100B, 1'b1, 16'h100D, 1'b0, 1'b0);
    issue(2'h1, BRA_MODE_POST_INC, 1'b0, 4'h3, 16'h0000);
    take(1'b1, 16'h2000, 1'b1, 16'h2002, 1'b0, 1'b0);
    issue(2'h1, BRA_MODE_PRE_DEC, 1'b0, 4'h2, 16'h0000);
    take(1'b1, 16'h100B, 1'b1, 16'h100B, 1'b0, 1'b0);
    issue(2'h1, BRA_MODE_OFFSET, 1'b0, 4'h2, 16'h0010);
    take(1'b1, 16'h101B, 1'b0, 16'h0000, 1'b0, 1'b0);
    issue(2'h1, BRA_MODE_DIRECT, 1'b0, 4'h2, 16'h0000);
    take(1'b1, 16'h100B, 1'b0, 16'h0000, 1'b0, 1'b0);
    // Modulo on W4 while reversal stays configured on W2.
    wr(BRA_OFS_XSTART, 16'h3000);
    wr(BRA_OFS_XEND, 16'h300F);
    wr(BRA_OFS_MODCTL, 16'h8042);
    load(4'h4, 16'h300E);
    issue(2'h1, BRA_MODE_POST_INC, 1'b0, 4'h4, 16'h0000);
    take(1'b1, 16'h300E, 1'b1, 16'h3010, 1'b0, 1'b0);
    issue(2'h0, BRA_MODE_POST_INC, 1'b0, 4'h4, 16'h0000);
    take(1'b1, 16'h3010, 1'b1, 16'h3002, 1'b0, 1'b1);
    // Enable cleared: X writes through W4 get modulo back and W2 steps without reversal.
    wr(BRA_OFS_REVCTL, 16'h0004);
    issue(2'h1, BRA_MODE_POST_INC, 1'b0, 4'h4, 16'h0000);
    take(1'b1, 16'h3002, 1'b1, 16'h3004, 1'b0, 1'b1);
    issue(2'h1, BRA_MODE_POST_INC, 1'b0, 4'h2, 16'h0000);
    take(1'b1, 16'h100B, 1'b1, 16'h100D, 1'b0, 1'b0);
    wr(BRA_OFS_MODCTL, 16'h0FFF);
    wr(BRA_OFS_REVCTL, 16'h8004);
    issue(2'h1, BRA_MODE_POST_INC, 1'b0, 4'h2, 16'h0000);
    take(1'b1, 16'h100D, 1'b1, 16'h100F, 1'b0, 1'b0);
    // Y unit: modulo folds a post-decrement unless reversal is configured.
    wr(BRA_OFS_YSTART, 16'h4000);
    wr(BRA_OFS_YEND, 16'h4007);
    rd(BRA_OFS_YEND, 16'h4007);
    wr(BRA_OFS_MODCTL, 16'h45FF);
    load(4'h5, 16'h4000);
    issue(2'h3, BRA_MODE_POST_DEC, 1'b0, 4'h5, 16'h0000);
    take(1'b1, 16'h4000, 1'b1, 16'h4006, 1'b0, 1'b1);
    wr(BRA_OFS_MODCTL, 16'h45F2);
    load(4'h5, 16'h4000);
    issue(2'h3, BRA_MODE_POST_DEC, 1'b0, 4'h5, 16'h0000);
    take(1'b1, 16'h4000, 1'b1, 16'h3FFE, 1'b0, 1'b0);
    rd(BRA_OFS_STATUS, 16'h0004);
    wr(BRA_OFS_LAST_EA, 16'hFFFF);
    rd(BRA_OFS_LAST_EA, 16'h4000);
    // Reset in mid-run: the answer and the control registers return to rest.
    @(posedge clk) nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    #1 chk(ea_addr, 16'h0000);
    rd(BRA_OFS_MODCTL, BRA_MODCTL_RST);
    rd(BRA_OFS_REVCTL, BRA_REVCTL_RST);
    give_verdict();
  end
endmodule : bra_addr_gen_tb_top

`default_nettype wire
